// [include/eeprom_fe_map.svh]
// Constants for the two-wire serial memory front end.
// Assumes a 4 ns system clock and a 64 ns link sampling clock.
`ifndef EEPROM_FE_MAP_SVH
`define EEPROM_FE_MAP_SVH

`define WORD_BITS          8
`define BIT_CNT_W          4
`define SEL_PINS           3
`define TYPE_MSB           7
`define TYPE_LSB           4
`define SEL_MSB            3
`define SEL_LSB            1
`define RW_BIT             0
`define QUAD_MSB           4
`define QUAD_LSB           3
`define UPPER_QUAD         2'h3
`define BYTE_IDX_DATA      2'h2
`define WRITE_CYCLE_TIME_NS  5000000
`define SYS_CLK_PERIOD_NS    4
`define NOISE_TIME_NS        100
`define LINK_CLK_PERIOD_NS   64

`endif

// [include/eeprom_fe_pkg.sv]
// Types shared by the two-wire serial memory front end.
// Assumes nothing beyond the map header.
`default_nettype none
package eeprom_fe_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WRITE,
		ST_READ
	} link_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_sample_t;

endpackage
`default_nettype wire

// [design/two_wire_eeprom_bus_front_end.sv]
// Slave front end of a two-wire serial memory: framing, addressing, ack,
// standby, write timing and upper-quadrant write protection.
// Assumes the bus pulls the data line high and link_clk_i oversamples it.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_fe_map.svh"

module two_wire_eeprom_bus_front_end #(
	parameter logic [3:0]  TYPE_CODE          = 4'h6, // Arbitrary value
	parameter int unsigned WRITE_CYCLE_CYCLES =
		`WRITE_CYCLE_TIME_NS / `SYS_CLK_PERIOD_NS,
	parameter int unsigned FILTER_SAMPLES     =
		(`NOISE_TIME_NS + `LINK_CLK_PERIOD_NS - 1) / `LINK_CLK_PERIOD_NS
) (
	input  wire logic        clk_i,           // System clock
	input  wire logic        reset_i,         // Async reset, high
	input  wire logic        link_clk_i,      // Bus sampling clock
	input  wire logic        scl_i,           // Serial clock pin
	input  wire logic        sda_i,           // Serial data pin level
	output logic             sda_o,           // Data drive value
	output logic             sda_oe_o,        // Data pulled low when high
	input  wire logic [2:0]  select_pin_i,    // Address straps
	input  wire logic        write_protect_i, // Upper quadrant lock
	output logic             standby_o,       // Low-power standby
	output logic             write_busy_o,    // Internal write running
	output logic             write_blocked_o  // Last write refused
);

	localparam int CNT_W = $clog2(WRITE_CYCLE_CYCLES + 1);

	generate
		if (FILTER_SAMPLES < 1 || WRITE_CYCLE_CYCLES < 1) begin : g_chk
			$error("Filter length and write cycle count must be >= 1");
		end
	endgenerate

	function automatic logic all_same(input logic [FILTER_SAMPLES-1:0] h,
		input logic lvl);
		all_same = lvl ? (&h) : ~(|h);
	endfunction

	// Link domain reset: async assert, release on link clock
	logic [1:0] rst_l_q;
	wire        rst_l = rst_l_q[1];

	always_ff @(posedge link_clk_i or posedge reset_i) begin
		if (reset_i)
			rst_l_q <= 2'h3;
		else
			rst_l_q <= {rst_l_q[0], 1'b0};
	end

	// Pin synchronisers and noise filter
	eeprom_fe_pkg::bus_sample_t s1_q;
	eeprom_fe_pkg::bus_sample_t s2_q;
	logic [2:0]                 sel1_q;
	logic [2:0]                 sel2_q;
	logic [FILTER_SAMPLES-1:0]  scl_h_q;
	logic [FILTER_SAMPLES-1:0]  sda_h_q;
	logic                       scl_f_q;
	logic                       sda_f_q;
	logic                       scl_p_q;
	logic                       sda_p_q;

	always_ff @(posedge link_clk_i or posedge rst_l) begin
		if (rst_l) begin
			s1_q   <= '1;
			s2_q   <= '1;
			sel1_q <= 3'h0;
			sel2_q <= 3'h0;
		end else begin
			s1_q   <= {scl_i, sda_i};
			s2_q   <= s1_q;
			sel1_q <= select_pin_i;
			sel2_q <= sel1_q;
		end
	end

	// Filter length covers the noise time; pulses shorter than one link clock never pass
	wire scl_f_d = all_same(scl_h_q, ~scl_f_q) ? ~scl_f_q : scl_f_q;
	wire sda_f_d = all_same(sda_h_q, ~sda_f_q) ? ~sda_f_q : sda_f_q;

	always_ff @(posedge link_clk_i or posedge rst_l) begin
		if (rst_l) begin
			scl_h_q <= '1;
			sda_h_q <= '1;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_h_q <= FILTER_SAMPLES'({scl_h_q, s2_q.scl});
			sda_h_q <= FILTER_SAMPLES'({sda_h_q, s2_q.sda});
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	wire scl_rise  = scl_f_q & ~scl_p_q;
	wire scl_fall  = ~scl_f_q & scl_p_q;
	wire scl_held  = scl_f_q & scl_p_q;
	wire start_det = scl_held & sda_p_q & ~sda_f_q;
	wire stop_det  = scl_held & ~sda_p_q & sda_f_q;

	// Link protocol engine
	eeprom_fe_pkg::link_state_t st_q;
	logic [`BIT_CNT_W-1:0]      bit_cnt_q;
	logic [`WORD_BITS-1:0]      shreg_q;
	logic                       ack_ph_q;
	logic                       sda_oe_q;
	logic [1:0]                 byte_idx_q;
	logic                       upper_q;
	logic                       wr_pend_q;
	logic                       wr_tgl_q;
	logic                       busy1_q;
	logic                       busy_l_q;

	wire receiving = (st_q == eeprom_fe_pkg::ST_ADDR) ||
		(st_q == eeprom_fe_pkg::ST_WRITE);
	wire word_full = bit_cnt_q == `BIT_CNT_W'(`WORD_BITS);
	wire shift_en  = receiving & scl_rise & ~word_full;
	wire word_done = receiving & word_full & scl_fall & ~ack_ph_q;
	wire ack_end   = ack_ph_q & scl_fall;
	wire in_addr   = st_q == eeprom_fe_pkg::ST_ADDR;
	wire type_ok   = shreg_q[`TYPE_MSB:`TYPE_LSB] == TYPE_CODE;
	wire sel_ok    = shreg_q[`SEL_MSB:`SEL_LSB] == sel2_q;
	wire addr_ok   = type_ok & sel_ok & ~busy_l_q;
	wire ack_ok    = in_addr ? addr_ok : 1'b1;
	wire rd_req    = shreg_q[`RW_BIT];
	wire upper_hit = shreg_q[`QUAD_MSB:`QUAD_LSB] == `UPPER_QUAD;

	always_ff @(posedge link_clk_i or posedge rst_l) begin
		if (rst_l) begin
			busy1_q  <= 1'b0;
			busy_l_q <= 1'b0;
		end else begin
			busy1_q  <= write_busy_o;
			busy_l_q <= busy1_q;
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_l) begin
		if (rst_l) begin
			st_q       <= eeprom_fe_pkg::ST_IDLE;
			bit_cnt_q  <= '0;
			shreg_q    <= '0;
			ack_ph_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
			byte_idx_q <= 2'h0;
			upper_q    <= 1'b0;
			wr_pend_q  <= 1'b0;
			wr_tgl_q   <= 1'b0;
		end else if (start_det) begin
			st_q      <= eeprom_fe_pkg::ST_ADDR;
			bit_cnt_q <= '0;
			ack_ph_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			wr_pend_q <= 1'b0;
		end else if (stop_det) begin
			if (st_q == eeprom_fe_pkg::ST_WRITE && wr_pend_q)
				wr_tgl_q <= ~wr_tgl_q;
			st_q      <= eeprom_fe_pkg::ST_IDLE;
			ack_ph_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			wr_pend_q <= 1'b0;
		end else begin
			if (shift_en) begin
				shreg_q   <= {shreg_q[`WORD_BITS-2:0], sda_f_q};
				bit_cnt_q <= bit_cnt_q + `BIT_CNT_W'(1);
			end
			if (word_done) begin
				sda_oe_q <= ack_ok;
				ack_ph_q <= ack_ok;
				case (st_q)
				eeprom_fe_pkg::ST_ADDR: begin
					byte_idx_q <= 2'h0;
					if (!addr_ok)
						st_q <= eeprom_fe_pkg::ST_IDLE;
					else if (rd_req)
						st_q <= eeprom_fe_pkg::ST_READ;
					else
						st_q <= eeprom_fe_pkg::ST_WRITE;
				end
				eeprom_fe_pkg::ST_WRITE: begin
					if (byte_idx_q == 2'h0)
						upper_q <= upper_hit;
					if (byte_idx_q == `BYTE_IDX_DATA)
						wr_pend_q <= 1'b1;
					else
						byte_idx_q <= byte_idx_q + 2'h1;
				end
				default: st_q <= st_q;
				endcase
			end
			if (ack_end) begin
				sda_oe_q  <= 1'b0;
				ack_ph_q  <= 1'b0;
				bit_cnt_q <= '0;
			end
		end
	end

	// Open drain: only ever pull low
	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_oe_q;

	wire idle_l = st_q == eeprom_fe_pkg::ST_IDLE;

	// System domain: write timer, protection, standby
	logic             tgl1_q;
	logic             tgl2_q;
	logic             tgl3_q;
	logic             up1_q;
	logic             up2_q;
	logic             wp1_q;
	logic             wp2_q;
	logic             idle1_q;
	logic             idle2_q;
	logic             busy_q;
	logic [CNT_W-1:0] wr_cnt_q;
	logic             blocked_q;
	logic             standby_q;

	// Upper flag is stable long before the toggle, so a level sync is safe
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tgl1_q  <= 1'b0;
			tgl2_q  <= 1'b0;
			tgl3_q  <= 1'b0;
			up1_q   <= 1'b0;
			up2_q   <= 1'b0;
			wp1_q   <= 1'b0;
			wp2_q   <= 1'b0;
			idle1_q <= 1'b1;
			idle2_q <= 1'b1;
		end else begin
			tgl1_q  <= wr_tgl_q;
			tgl2_q  <= tgl1_q;
			tgl3_q  <= tgl2_q;
			up1_q   <= upper_q;
			up2_q   <= up1_q;
			wp1_q   <= write_protect_i;
			wp2_q   <= wp1_q;
			idle1_q <= idle_l;
			idle2_q <= idle1_q;
		end
	end

	wire wr_evt   = tgl2_q ^ tgl3_q;
	wire wr_block = wp2_q & up2_q;
	wire wr_last  = wr_cnt_q == CNT_W'(WRITE_CYCLE_CYCLES - 1);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_q    <= 1'b0;
			wr_cnt_q  <= '0;
			blocked_q <= 1'b0;
			standby_q <= 1'b1;
		end else begin
			standby_q <= idle2_q & ~busy_q & ~wr_evt;
			if (wr_evt) begin
				blocked_q <= wr_block;
				busy_q    <= ~wr_block;
				wr_cnt_q  <= '0;
			end else if (busy_q) begin
				wr_cnt_q <= wr_cnt_q + CNT_W'(1);
				if (wr_last)
					busy_q <= 1'b0;
			end
		end
	end

	assign standby_o       = standby_q;
	assign write_busy_o    = busy_q;
	assign write_blocked_o = blocked_q;

	// Checks, link domain
	property p_ack_on_fall;
		@(posedge link_clk_i) disable iff (rst_l)
		$rose(sda_oe_q) |-> $past(scl_fall) && $past(word_full);
	endproperty
	a_ack_on_fall: assert property (p_ack_on_fall)
		else $error("Ack driven away from a falling clock edge");

	property p_nack_mismatch;
		@(posedge link_clk_i) disable iff (rst_l)
		word_done && in_addr && !(type_ok && sel_ok) && !start_det && !stop_det
		|=> !sda_oe_q && st_q == eeprom_fe_pkg::ST_IDLE;
	endproperty
	a_nack_mismatch: assert property (p_nack_mismatch)
		else $error("Mismatched address was acknowledged");

	property p_ack_match;
		@(posedge link_clk_i) disable iff (rst_l)
		word_done && in_addr && addr_ok && !start_det && !stop_det
		|=> (sda_oe_q && ack_ph_q) [*2];
	endproperty
	a_ack_match: assert property (p_ack_match)
		else $error("Matching address not acknowledged");

	property p_busy_nack;
		@(posedge link_clk_i) disable iff (rst_l)
		word_done && in_addr && busy_l_q |=> !sda_oe_q;
	endproperty
	a_busy_nack: assert property (p_busy_nack)
		else $error("Address acknowledged during write cycle");

	property p_start;
		@(posedge link_clk_i) disable iff (rst_l)
		start_det |=> st_q == eeprom_fe_pkg::ST_ADDR && bit_cnt_q == 0;
	endproperty
	a_start: assert property (p_start)
		else $error("Start did not open an address phase");

	property p_stop;
		@(posedge link_clk_i) disable iff (rst_l)
		stop_det |=> st_q == eeprom_fe_pkg::ST_IDLE && !sda_oe_q;
	endproperty
	a_stop: assert property (p_stop)
		else $error("Stop did not end the transaction");

	property p_filter;
		@(posedge link_clk_i) disable iff (rst_l)
		$changed(scl_f_q) |-> all_same($past(scl_h_q), scl_f_q);
	endproperty
	a_filter: assert property (p_filter)
		else $error("Clock level passed the filter too early");

	property p_msb_first;
		@(posedge link_clk_i) disable iff (rst_l)
		shift_en && !start_det && !stop_det
		|=> shreg_q[0] == $past(sda_f_q) && shreg_q[7:1] == $past(shreg_q[6:0]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("Bit not shifted in most significant first");

	// Checks, system domain
	property p_wr_time;
		@(posedge clk_i) disable iff (reset_i)
		busy_q |-> wr_cnt_q < CNT_W'(WRITE_CYCLE_CYCLES);
	endproperty
	a_wr_time: assert property (p_wr_time)
		else $error("Write cycle ran past its time");

	property p_protect;
		@(posedge clk_i) disable iff (reset_i)
		wr_evt && wr_block |=> !busy_q && blocked_q;
	endproperty
	a_protect: assert property (p_protect)
		else $error("Protected write was started");

	property p_standby;
		@(posedge clk_i) disable iff (reset_i)
		busy_q |=> !standby_q;
	endproperty
	a_standby: assert property (p_standby)
		else $error("Standby during internal write");

	c_addr_ack: cover property (@(posedge link_clk_i) disable iff (rst_l)
		word_done && in_addr && addr_ok);
	c_write: cover property (@(posedge clk_i) disable iff (reset_i)
		wr_evt && !wr_block);
	c_read_stop: cover property (@(posedge link_clk_i) disable iff (rst_l)
		stop_det && st_q == eeprom_fe_pkg::ST_READ);

endmodule
`default_nettype wire

// [testbench/two_wire_master_model.sv]
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model #(
	parameter int Q = 64 // Quarter bit time in system clocks
) (
	input  wire logic clk_i,     // Timing reference
	input  wire logic sda_i,     // Resolved data line
	output logic      scl_o,     // Serial clock, high when idle
	output logic      sda_low_o  // High pulls data low
);
	logic glitch_en = 1'b0;

	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic wq();
		repeat (Q) @(posedge clk_i);
		#1;
	endtask

	task automatic put_bit(input logic v, output logic seen);
		wq();
		if (glitch_en) begin
			scl_o = 1'b1;
			#40 scl_o = 1'b0;
		end
		sda_low_o = ~v;
		wq();
		scl_o = 1'b1;
		wq();
		seen = sda_i;
		wq();
		scl_o = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack,
		output logic clash);
		logic seen;
		clash = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], seen);
			if (b[i] && seen !== 1'b1)
				clash = 1'b1;
		end
		put_bit(1'b1, seen);
		ack = (seen === 1'b0);
	endtask

	task automatic start_cond();
		wq();
		sda_low_o = 1'b0;
		wq();
		scl_o = 1'b1;
		wq();
		sda_low_o = 1'b1;
		wq();
		scl_o = 1'b0;
	endtask

	task automatic stop_cond();
		wq();
		sda_low_o = 1'b1;
		wq();
		scl_o = 1'b1;
		wq();
		sda_low_o = 1'b0;
		wq();
	endtask

	// Nine clocks with the data line released, then a start, as a real master frees the bus
	task automatic recover();
		logic seen;
		for (int i = 0; i < 9; i++)
			put_bit(1'b1, seen);
		start_cond();
	endtask
endmodule
`default_nettype wire

// [testbench/two_wire_eeprom_bus_front_end_tb_top.sv]
// Self-checking bench: master model on the bus, random and corner cases.
// Assumes the front end and the map header are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_fe_map.svh"
module two_wire_eeprom_bus_front_end_tb_top;
	localparam logic [3:0] TYPE = 4'h6; // Arbitrary type code
	localparam int         WRC  = 4000; // Shortened write cycle

	logic       clk_i      = 1'b0;
	logic       link_clk_i = 1'b0;
	logic       reset_i    = 1'b0;
	logic       wp         = 1'b0;
	logic [2:0] sel        = 3'h0;
	logic       sel_float  = 1'b0;
	tri0  [2:0] sel_pins;
	wire logic  sda_line;
	logic       scl;
	logic       m_low;
	logic       sda_oe;
	logic       sda_drv;
	logic       standby;
	logic       busy;
	logic       blocked;
	int         errors     = 0;
	int         tests_run  = 0;
	int         busy_cnt   = 0;
	int         busy_len   = 0;

	// Board pull-down stands in for a floating strap
	assign sel_pins = sel_float ? 3'hZ : sel;
	assign sda_line = ~(m_low | (sda_oe & ~sda_drv));

	two_wire_eeprom_bus_front_end #(
		.TYPE_CODE          (TYPE),
		.WRITE_CYCLE_CYCLES (WRC)
	) u_dut (
		.clk_i           (clk_i),
		.reset_i         (reset_i),
		.link_clk_i      (link_clk_i),
		.scl_i           (scl),
		.sda_i           (sda_line),
		.sda_o           (sda_drv),
		.sda_oe_o        (sda_oe),
		.select_pin_i    (sel_pins),
		.write_protect_i (wp),
		.standby_o       (standby),
		.write_busy_o    (busy),
		.write_blocked_o (blocked)
	);

	two_wire_master_model #(
		.Q (64)
	) u_master (
		.clk_i     (clk_i),
		.sda_i     (sda_line),
		.scl_o     (scl),
		.sda_low_o (m_low)
	);

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		#13.7;
		forever #32 link_clk_i = ~link_clk_i;
	end

	always @(posedge clk_i) begin
		if (busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
		else if (busy_cnt != 0) begin
			busy_len <= busy_cnt;
			busy_cnt <= 0;
		end
	end

	task automatic check(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	function automatic logic want_ack(input logic [7:0] a,
		input logic [2:0] s);
		return a[`TYPE_MSB:`TYPE_LSB] == TYPE && a[`SEL_MSB:`SEL_LSB] == s;
	endfunction

	function automatic logic want_block(input logic w, input logic [7:0] h);
		return w && h[`QUAD_MSB:`QUAD_LSB] == `UPPER_QUAD;
	endfunction

	task automatic tx(input logic [7:0] b, input logic exp, input string w);
		logic ack;
		logic clash;
		u_master.send_byte(b, ack, clash);
		check(ack === exp, w);
		check(clash === 1'b0, "device drove a data bit");
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		// Tests take about 300 us; stay under 100k system clocks
		#380000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		logic [7:0] a;
		logic [7:0] hi;
		logic       rw;
		void'($urandom(32'hAA55539B));
		// Raised after time zero so both domains see a reset edge
		#1 reset_i = 1'b1;
		repeat (6) @(posedge clk_i);
		#1;
		check(standby === 1'b1 && busy === 1'b0, "reset levels");
		check(blocked === 1'b0 && sda_oe === 1'b0, "reset outs");
		check(sda_drv === 1'b0, "data drive level");
		reset_i = 1'b0;
		repeat (10) @(posedge link_clk_i);
		check(standby === 1'b1, "standby at power-up");
		@(posedge clk_i) #1 sel_float = 1'b1;
		u_master.glitch_en = 1'b1;
		u_master.recover();
		tx({TYPE, 3'h0, 1'b0}, 1'b1, "floating straps");
		u_master.glitch_en = 1'b0;
		u_master.stop_cond();
		sel_float = 1'b0;
		for (int n = 0; n < 5; n++) begin
			@(posedge clk_i) #1 sel = 3'($urandom);
			rw = 1'(n >> 1);
			a = (n % 2 == 0) ? {TYPE, sel, rw} : 8'($urandom);
			if (n == 1)
				a = {TYPE, sel + 3'h1, rw};
			if (n == 3)
				a[7] = ~TYPE[3];
			u_master.start_cond();
			tx(a, want_ack(a, sel), "address ack");
			if (want_ack(a, sel))
				tx(8'h00, ~rw, "direction after match");
			else
				tx({TYPE, sel, 1'b0}, 1'b0, "ignored after miss");
			u_master.stop_cond();
			repeat (300) @(posedge clk_i);
			#1;
			check(standby === 1'b1, "standby after stop");
		end
		for (int c = 0; c < 3; c++) begin
			@(posedge clk_i) #1 wp = (c != 1);
			hi = 8'($urandom);
			hi[`QUAD_MSB:`QUAD_LSB] = (c == 2) ? 2'h1 : `UPPER_QUAD;
			u_master.start_cond();
			tx({TYPE, sel, 1'b0}, 1'b1, "write address");
			tx(hi, 1'b1, "word address high");
			tx(8'($urandom), 1'b1, "word address low");
			tx(8'($urandom), 1'b1, "data word");
			u_master.stop_cond();
			repeat (100) @(posedge clk_i);
			#1;
			check(blocked === want_block(wp, hi), "protect");
			check(busy === ~want_block(wp, hi), "write start");
			check(standby === want_block(wp, hi), "standby in write");
			if (busy === 1'b1) begin
				u_master.start_cond();
				tx({TYPE, sel, 1'b0}, 1'b0, "poll while busy");
				u_master.stop_cond();
				for (int k = 0; k < 6000 && busy !== 1'b0; k++)
					@(posedge clk_i);
				repeat (300) @(posedge clk_i);
				#1;
				check(busy_len >= WRC - 2 && busy_len <= WRC + 2,
					"write cycle time");
				check(standby === 1'b1, "standby after write");
				u_master.start_cond();
				tx({TYPE, sel, 1'b0}, 1'b1, "poll after write");
				u_master.stop_cond();
			end
		end
		close_out();
	end
endmodule
`default_nettype wire
